// ### design/lpm_pkg.sv
// Constants, mode codes and widths shared by the low-power sequencer and its wake qualifier.
package lpm_pkg;

    // ------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------
    localparam int unsigned CNT_W = 18;
    localparam int unsigned MODE_W = 2;
    localparam int unsigned QPRD_W = 8;
    localparam int unsigned SQUAL_W = 6;
    localparam int unsigned DIV_W = 8;

    // ------------------------------------------------------------
    // Clock rates
    // ------------------------------------------------------------
    // The system clock equals core_clk; the oscillator rate is a divided enable.
    localparam int unsigned CORE_CLK_MHZ = 50;
    localparam int unsigned OSC_DIV = 2;

    // ------------------------------------------------------------
    // Timing counts, in cycles of the named clock
    // ------------------------------------------------------------
    localparam int unsigned FLUSH_SYS_CYCLES = 32;
    localparam int unsigned IDLE_WAKE_MIN_SYS = 2;
    localparam int unsigned IQT_WINDOWS = 5;
    localparam int unsigned IQT_PERIOD_MUL = 2;
    localparam int unsigned IQT_BASE_SYS = 1;
    localparam int unsigned IDLE_RESUME_FAST_SYS = 8;
    localparam int unsigned IDLE_RESUME_SLEEP_SYS = 1050;
    localparam int unsigned STBY_WAKE_MIN_OSC = 12;
    localparam int unsigned STBY_QUAL_BASE_OSC = 2;
    localparam int unsigned STBY_RESUME_FAST_OSC = 12;
    localparam int unsigned STBY_RESUME_SLEEP_SYS = 1125;
    localparam int unsigned HALT_NMI_MIN_OSC = 2;
    localparam int unsigned HALT_RST_MIN_OSC = 8;
    localparam int unsigned PLL_LOCK_OSC = 131072;
    localparam int unsigned HALT_RESUME_SLEEP_SYS = 1125;
    localparam int unsigned HALT_RESUME_RAM_SYS = 35;

    // ------------------------------------------------------------
    // Low-power mode codes
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_IDLE = 2'h0;
    localparam logic [MODE_W-1:0] MODE_STANDBY = 2'h1;
    localparam logic [MODE_W-1:0] MODE_HALT = 2'h2;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [MODE_W-1:0] MODE_RESET = MODE_IDLE;
    localparam logic CLK_EN_RESET = 1'h1;
    localparam logic XCLK_RESET = 1'h0;

endpackage

// ### design/wake_qual_if.sv
// Signals between the sequencer and its wake pulse qualifier.
`timescale 1ns/10ps
interface wake_qual_if;
    logic tick;
    logic level;
    logic clear;
    logic [lpm_pkg::CNT_W-1:0] need;
    logic hit;

    modport qual (
        input tick,
        input level,
        input clear,
        input need,
        output hit
    );

    modport ctrl (
        output tick,
        output level,
        output clear,
        output need,
        input hit
    );
endinterface

// ### design/wake_qual.sv
// Wake pulse qualifier: counts consecutive active ticks and flags a wake once enough are seen.
`timescale 1ns/10ps
module wake_qual (
    input wire logic core_clk,
    input wire logic rst,
    wake_qual_if.qual port
);
    import lpm_pkg::*;

    typedef struct packed {
        logic [CNT_W-1:0] cnt;
        logic hit;
    } qual_s;

    qual_s st;
    qual_s next_st;

    // ------------------------------------------------------------
    // Counting
    // ------------------------------------------------------------
    // A pulse that drops before the threshold restarts the count, so a glitch never wakes.
    always_comb begin
        next_st = st;
        if (port.tick && port.level) begin
            if (st.cnt != port.need) begin
                next_st.cnt = st.cnt + CNT_W'(1);
            end
            if ((st.cnt + CNT_W'(1)) >= port.need) begin
                next_st.hit = 1'b1;
            end
        end else if (port.tick) begin
            next_st.cnt = '0;
        end
        // A hit in the same cycle as the clear survives.
        if (port.clear && !next_st.hit) begin
            next_st.cnt = '0;
        end else if (port.clear && st.hit) begin
            next_st = '0;
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign port.hit = st.hit;

endmodule // wake_qual

// ### design/lpm_sequencer.sv
// Low-power mode sequencer: entry flush, wake qualification, oscillator and PLL restart, resume delays.
//
// Operation
// - Qualified IDLE wake needs one cycle plus five times period times two.
// - IDLE wake with active flash or RAM resumes after eight system cycles.
// - IDLE wake with sleeping flash resumes after 1050 system cycles.
// - Resume marks the instruction after IDLE; interrupt servicing comes later.
// - IDLE ends on enabled interrupt, watchdog wake, NMI pin or reset pin.
// - Standby entry keeps the system clock running 32 cycles before stopping.
// - Standby wake pulse: twelve oscillator cycles, or two plus qualifier count.
// - Standby resume: twelve oscillator cycles, or 1125 system cycles from sleeping flash.
// - Standby exits after latency; interrupt answered only when enabled.
// - Halt entry keeps the system clock 32 cycles, then stops oscillator and core.
// - In halt all clocks, oscillator and PLL are off.
// - NMI in halt restarts the oscillator; PLL waits for pin release.
// - NMI release starts a 131072 oscillator cycle PLL lock before core clock.
// - After lock, resume after 1125 cycles from sleeping flash or 35 from RAM.
// - On halt entry the external clock goes high 32 system cycles after IDLE.
// - The IDLE instruction enters whichever low-power mode is selected.
`timescale 1ns/10ps
module lpm_sequencer #(
    parameter int unsigned PLL_LOCK_CYCLES = lpm_pkg::PLL_LOCK_OSC,
    parameter int unsigned OSC_DIVIDE = lpm_pkg::OSC_DIV
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic idle_exec,
    input wire logic [lpm_pkg::MODE_W-1:0] lpm_mode,
    input wire logic qual_enable,
    input wire logic [lpm_pkg::QPRD_W-1:0] input_qual_period,
    input wire logic [lpm_pkg::SQUAL_W-1:0] standby_qual_count,
    input wire logic flash_asleep,
    input wire logic run_from_ram,
    input wire logic periph_int,
    input wire logic periph_int_en,
    input wire logic watchdog_wake_int,
    input wire logic nonmaskable_int_pin_n,
    input wire logic reset_pin_n,
    output logic core_clock_en,
    output logic sys_clock_en,
    output logic osc_enable,
    output logic pll_enable,
    output logic external_clock_out,
    output logic exec_resume,
    output logic wake_irq,
    output logic in_low_power
);
    import lpm_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_RUN,
        ST_FLUSH,
        ST_IDLE,
        ST_STBY,
        ST_HALT,
        ST_HALT_OSC,
        ST_PLL,
        ST_RESUME
    } seq_state_e;

    typedef struct packed {
        seq_state_e state;
        logic nmi_s1;
        logic nmi_s2;
        logic rs_s1;
        logic rs_s2;
        logic [MODE_W-1:0] mode;
        logic [CNT_W-1:0] cnt;
        logic res_osc;
        logic [DIV_W-1:0] div;
        logic osc_tick;
        logic irq_pend;
        logic core_en;
        logic sys_en;
        logic osc_en;
        logic pll_en;
        logic xclk;
        logic resume;
        logic irq;
        logic lp;
    } seq_s;

    localparam seq_s SEQ_RESET = '{
        state: ST_RUN,
        mode: MODE_RESET,
        core_en: CLK_EN_RESET,
        sys_en: CLK_EN_RESET,
        osc_en: CLK_EN_RESET,
        pll_en: CLK_EN_RESET,
        xclk: XCLK_RESET,
        default: '0
    };

    localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(OSC_DIVIDE - 1);
    localparam logic [CNT_W-1:0] LOCK_CNT = CNT_W'(PLL_LOCK_CYCLES);
    localparam logic [CNT_W-1:0] IQT_MUL = CNT_W'(IQT_WINDOWS * IQT_PERIOD_MUL);

    seq_s st;
    seq_s next_st;
    wake_qual_if wq ();

    logic int_hit;
    logic any_wake;
    logic [CNT_W-1:0] idle_need;
    logic [CNT_W-1:0] stby_need;

    wake_qual u_wake_qual (
        .core_clk(core_clk),
        .rst(rst),
        .port(wq.qual)
    );

    // ------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------
    always_comb begin
        next_st = st;
        // Pin levels arrive asynchronously; only the second stage is used below.
        next_st.nmi_s1 = ~nonmaskable_int_pin_n;
        next_st.nmi_s2 = st.nmi_s1;
        next_st.rs_s1 = ~reset_pin_n;
        next_st.rs_s2 = st.rs_s1;
        next_st.resume = 1'b0;
        next_st.irq = 1'b0;

        // Oscillator-rate enable, kept running so halt pins can still be timed.
        if (st.div == DIV_LAST) begin
            next_st.div = '0;
            next_st.osc_tick = 1'b1;
        end else begin
            next_st.div = st.div + DIV_W'(1);
            next_st.osc_tick = 1'b0;
        end

        int_hit = periph_int & periph_int_en;
        any_wake = int_hit | watchdog_wake_int | st.nmi_s2 | st.rs_s2;
        idle_need = qual_enable ? CNT_W'(IQT_BASE_SYS) + IQT_MUL * CNT_W'(input_qual_period)
                                : CNT_W'(IDLE_WAKE_MIN_SYS);
        stby_need = qual_enable ? CNT_W'(STBY_QUAL_BASE_OSC) + CNT_W'(standby_qual_count)
                                : CNT_W'(STBY_WAKE_MIN_OSC);

        wq.tick = 1'b1;
        wq.level = 1'b0;
        wq.clear = 1'b1;
        wq.need = idle_need;

        case (st.state)
            ST_RUN: begin
                next_st.mode = lpm_mode;
                if (idle_exec) begin
                    next_st.lp = 1'b1;
                    next_st.irq_pend = 1'b0;
                    if (st.mode == MODE_IDLE) begin
                        next_st.core_en = 1'b0;
                        next_st.state = ST_IDLE;
                    end else begin
                        next_st.cnt = CNT_W'(FLUSH_SYS_CYCLES);
                        next_st.state = ST_FLUSH;
                    end
                end
            end
            ST_FLUSH: begin
                if (st.cnt <= CNT_W'(1)) begin
                    next_st.cnt = '0;
                    next_st.core_en = 1'b0;
                    next_st.sys_en = 1'b0;
                    if (st.mode == MODE_HALT) begin
                        next_st.osc_en = 1'b0;
                        next_st.pll_en = 1'b0;
                        next_st.state = ST_HALT;
                    end else begin
                        next_st.state = ST_STBY;
                    end
                end else begin
                    next_st.cnt = st.cnt - CNT_W'(1);
                end
            end
            ST_IDLE: begin
                wq.clear = 1'b0;
                wq.level = any_wake;
                next_st.irq_pend = st.irq_pend | int_hit | watchdog_wake_int | st.nmi_s2;
                if (wq.hit) begin
                    next_st.res_osc = 1'b0;
                    if (flash_asleep && !run_from_ram) begin
                        next_st.cnt = CNT_W'(IDLE_RESUME_SLEEP_SYS);
                    end else begin
                        next_st.cnt = CNT_W'(IDLE_RESUME_FAST_SYS);
                    end
                    next_st.state = ST_RESUME;
                end
            end
            ST_STBY: begin
                wq.clear = 1'b0;
                wq.tick = st.osc_tick;
                wq.level = periph_int | watchdog_wake_int | st.nmi_s2 | st.rs_s2;
                wq.need = stby_need;
                // A peripheral interrupt is answered after the wake only when enabled.
                next_st.irq_pend = st.irq_pend | int_hit | watchdog_wake_int | st.nmi_s2;
                if (wq.hit) begin
                    next_st.sys_en = 1'b1;
                    if (flash_asleep && !run_from_ram) begin
                        next_st.res_osc = 1'b0;
                        next_st.cnt = CNT_W'(STBY_RESUME_SLEEP_SYS);
                    end else begin
                        next_st.res_osc = 1'b1;
                        next_st.cnt = CNT_W'(STBY_RESUME_FAST_OSC);
                    end
                    next_st.state = ST_RESUME;
                end
            end
            ST_HALT: begin
                wq.clear = 1'b0;
                wq.tick = st.osc_tick;
                wq.level = st.nmi_s2 | st.rs_s2;
                wq.need = st.rs_s2 ? CNT_W'(HALT_RST_MIN_OSC) : CNT_W'(HALT_NMI_MIN_OSC);
                next_st.irq_pend = st.irq_pend | st.nmi_s2;
                if (wq.hit) begin
                    next_st.osc_en = 1'b1;
                    next_st.state = ST_HALT_OSC;
                end
            end
            ST_HALT_OSC: begin
                if (!st.nmi_s2 && !st.rs_s2) begin
                    next_st.pll_en = 1'b1;
                    next_st.cnt = LOCK_CNT;
                    next_st.state = ST_PLL;
                end
            end
            ST_PLL: begin
                if (st.osc_tick) begin
                    if (st.cnt <= CNT_W'(1)) begin
                        next_st.sys_en = 1'b1;
                        next_st.res_osc = 1'b0;
                        if (flash_asleep && !run_from_ram) begin
                            next_st.cnt = CNT_W'(HALT_RESUME_SLEEP_SYS);
                        end else begin
                            next_st.cnt = CNT_W'(HALT_RESUME_RAM_SYS);
                        end
                        next_st.state = ST_RESUME;
                    end else begin
                        next_st.cnt = st.cnt - CNT_W'(1);
                    end
                end
            end
            ST_RESUME: begin
                if (st.osc_tick || !st.res_osc) begin
                    if (st.cnt <= CNT_W'(1)) begin
                        next_st.cnt = '0;
                        next_st.core_en = 1'b1;
                        next_st.sys_en = 1'b1;
                        next_st.resume = 1'b1;
                        next_st.irq = st.irq_pend;
                        next_st.irq_pend = 1'b0;
                        next_st.lp = 1'b0;
                        next_st.state = ST_RUN;
                    end else begin
                        next_st.cnt = st.cnt - CNT_W'(1);
                    end
                end
            end
            default: begin
                next_st = SEQ_RESET;
            end
        endcase

        // The external clock follows the system clock and parks high while it is stopped.
        next_st.xclk = next_st.sys_en ? ~st.xclk : 1'b1;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            st <= SEQ_RESET;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign core_clock_en = st.core_en;
    assign sys_clock_en = st.sys_en;
    assign osc_enable = st.osc_en;
    assign pll_enable = st.pll_en;
    assign external_clock_out = st.xclk;
    assign exec_resume = st.resume;
    assign wake_irq = st.irq;
    assign in_low_power = st.lp;

endmodule // lpm_sequencer

// ### bench/lpm_chk.sv
// Port checker for the low-power sequencer, bound to its top module.
`timescale 1ns/10ps
module lpm_chk #(
    parameter int unsigned PLL_LOCK_CYCLES = 16,
    parameter int unsigned OSC_DIVIDE = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic idle_exec,
    input wire logic [lpm_pkg::MODE_W-1:0] lpm_mode,
    input wire logic nonmaskable_int_pin_n,
    input wire logic core_clock_en,
    input wire logic sys_clock_en,
    input wire logic osc_enable,
    input wire logic pll_enable,
    input wire logic external_clock_out,
    input wire logic exec_resume,
    input wire logic wake_irq,
    input wire logic in_low_power
);
    import lpm_pkg::*;
    // The lock window allows for pin sync and tick alignment around the nominal count.
    localparam int LOCK_LO = PLL_LOCK_CYCLES * OSC_DIVIDE - 12;
    localparam int LOCK_HI = PLL_LOCK_CYCLES * OSC_DIVIDE;
    wire take = idle_exec && !in_low_power;
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    idle_gate_a: assert property (take && $past(lpm_mode) == MODE_IDLE |=> !core_clock_en && in_low_power)
        else $error("core clock not gated after idle entry");
    flush_hold_a: assert property (take && $past(lpm_mode) != MODE_IDLE |-> ##25 sys_clock_en [*8] ##1 !sys_clock_en)
        else $error("system clock not held for the flush");
    halt_off_a: assert property (take && $past(lpm_mode) == MODE_HALT |-> ##33 !osc_enable && !pll_enable)
        else $error("oscillator or pll still on in halt");
    stop_high_a: assert property (!sys_clock_en |-> external_clock_out)
        else $error("external clock not high while stopped");
    resume_once_a: assert property (exec_resume |-> core_clock_en && !in_low_power ##1 !exec_resume)
        else $error("resume pulse malformed");
    irq_pair_a: assert property (wake_irq |-> exec_resume)
        else $error("wake interrupt without resume");
    osc_first_a: assert property ($rose(pll_enable) |-> osc_enable && $past(nonmaskable_int_pin_n, 2))
        else $error("pll started before oscillator or pin release");
    lock_wait_a: assert property ($rose(pll_enable) |-> !sys_clock_en [*8] ##[LOCK_LO:LOCK_HI] $rose(sys_clock_en))
        else $error("system clock not back after pll lock");
endmodule // lpm_chk

bind lpm_sequencer lpm_chk #(.PLL_LOCK_CYCLES(PLL_LOCK_CYCLES), .OSC_DIVIDE(OSC_DIVIDE)) chk (
    .core_clk(core_clk),
    .rst(rst),
    .idle_exec(idle_exec),
    .lpm_mode(lpm_mode),
    .nonmaskable_int_pin_n(nonmaskable_int_pin_n),
    .core_clock_en(core_clock_en),
    .sys_clock_en(sys_clock_en),
    .osc_enable(osc_enable),
    .pll_enable(pll_enable),
    .external_clock_out(external_clock_out),
    .exec_resume(exec_resume),
    .wake_irq(wake_irq),
    .in_low_power(in_low_power)
);

// ### bench/wake_src.sv
// Model of the external wake sources: interrupt, watchdog, NMI pin and reset pin.
`timescale 1ns/10ps
module wake_src (
    input wire logic core_clk,
    output logic periph_int,
    output logic watchdog_wake_int,
    output logic nonmaskable_int_pin_n,
    output logic reset_pin_n
);
    // The pins idle high on their pull-ups once released.
    initial begin
        periph_int = 1'h0;
        watchdog_wake_int = 1'h0;
        nonmaskable_int_pin_n = 1'h1;
        reset_pin_n = 1'h1;
    end

    // ------------------------------------------------------------
    // One wake pulse of a given length in system cycles
    // ------------------------------------------------------------
    task automatic pulse(input int kind, input int len);
        @(posedge core_clk);
        #1;
        case (kind)
            0: periph_int = 1'h1;
            1: watchdog_wake_int = 1'h1;
            2: nonmaskable_int_pin_n = 1'h0;
            default: reset_pin_n = 1'h0;
        endcase
        repeat (len) @(posedge core_clk);
        #1;
        periph_int = 1'h0;
        watchdog_wake_int = 1'h0;
        nonmaskable_int_pin_n = 1'h1;
        reset_pin_n = 1'h1;
    endtask
endmodule // wake_src

// ### bench/tb.sv
// Self-checking testbench for the low-power sequencer.
`timescale 1ns/10ps
module tb;
    import lpm_pkg::*;
    logic core_clk = 1'h0;
    logic rst = 1'h1;
    logic idle_exec = 1'h0;
    logic [MODE_W-1:0] lpm_mode = MODE_IDLE;
    logic qual_enable = 1'h0;
    logic [QPRD_W-1:0] input_qual_period = 8'h01;
    logic [SQUAL_W-1:0] standby_qual_count = 6'h05;
    logic flash_asleep = 1'h0;
    logic run_from_ram = 1'h0;
    logic periph_int_en = 1'h1;
    logic periph_int, watchdog_wake_int, nonmaskable_int_pin_n, reset_pin_n;
    logic core_clock_en, sys_clock_en, osc_enable, pll_enable;
    logic external_clock_out, exec_resume, wake_irq, in_low_power;
    int mismatches = 0;
    int total_checks = 0;

    always #10 core_clk = ~core_clk;

    lpm_sequencer #(.PLL_LOCK_CYCLES(16), .OSC_DIVIDE(2)) uut (
        .core_clk(core_clk),
        .rst(rst),
        .idle_exec(idle_exec),
        .lpm_mode(lpm_mode),
        .qual_enable(qual_enable),
        .input_qual_period(input_qual_period),
        .standby_qual_count(standby_qual_count),
        .flash_asleep(flash_asleep),
        .run_from_ram(run_from_ram),
        .periph_int(periph_int),
        .periph_int_en(periph_int_en),
        .watchdog_wake_int(watchdog_wake_int),
        .nonmaskable_int_pin_n(nonmaskable_int_pin_n),
        .reset_pin_n(reset_pin_n),
        .core_clock_en(core_clock_en),
        .sys_clock_en(sys_clock_en),
        .osc_enable(osc_enable),
        .pll_enable(pll_enable),
        .external_clock_out(external_clock_out),
        .exec_resume(exec_resume),
        .wake_irq(wake_irq),
        .in_low_power(in_low_power)
    );

    wake_src src (
        .core_clk(core_clk),
        .periph_int(periph_int),
        .watchdog_wake_int(watchdog_wake_int),
        .nonmaskable_int_pin_n(nonmaskable_int_pin_n),
        .reset_pin_n(reset_pin_n)
    );

    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic summarize();
        if (mismatches == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask

    task automatic enter(input logic [MODE_W-1:0] m);
        cyc(1);
        lpm_mode = m;
        cyc(1);
        idle_exec = 1'h1;
        cyc(1);
        idle_exec = 1'h0;
    endtask

    // Counts cycles until the resume pulse; a hang ends the run.
    task automatic wait_resume(output int n, output logic irq);
        n = 0;
        while (exec_resume !== 1'h1) begin
            cyc(1);
            n++;
            if (n > 3000) begin
                mismatches++;
                summarize();
            end
        end
        irq = wake_irq;
    endtask

    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic idle_case(input int k, input logic q, input logic slp, input int len, input int lo,
                             input logic eirq);
        int n;
        logic irq;
        qual_enable = q;
        flash_asleep = slp;
        enter(MODE_IDLE);
        check(core_clock_en, 1'h0);
        fork
            src.pulse(k, len);
            wait_resume(n, irq);
        join
        check(n + 2 >= lo && n <= lo + 12, 1'h1);
        check(irq, eirq);
    endtask

    task automatic idle_refuse();
        int n;
        logic irq;
        qual_enable = 1'h0;
        flash_asleep = 1'h0;
        periph_int_en = 1'h0;
        enter(MODE_IDLE);
        src.pulse(0, 6);
        src.pulse(1, 1);
        cyc(12);
        check(in_low_power, 1'h1);
        fork
            src.pulse(1, 2);
            wait_resume(n, irq);
        join
        check(irq, 1'h1);
        periph_int_en = 1'h1;
    endtask

    task automatic deep_case(input logic [MODE_W-1:0] m, input int k, input logic q, input logic slp,
                             input int len, input int lo, input logic eirq);
        int n;
        logic irq;
        logic on;
        on = (m != MODE_HALT);
        qual_enable = q;
        flash_asleep = slp;
        enter(m);
        cyc(29);
        check(sys_clock_en, 1'h1);
        cyc(6);
        check({sys_clock_en, osc_enable, pll_enable, external_clock_out}, {1'h0, on, on, 1'h1});
        fork
            src.pulse(k, len);
            wait_resume(n, irq);
            begin
                // The reset pin needs eight oscillator ticks before the oscillator comes back.
                cyc((k == 2) ? 8 : 21);
                if (!on)
                    check({osc_enable, pll_enable}, 2'h2);
            end
        join
        check(n + 2 >= lo && n <= lo + 12, 1'h1);
        check(irq, eirq);
    endtask

    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        cyc(10);
        rst = 1'h0;
        check({core_clock_en, sys_clock_en, osc_enable, pll_enable, exec_resume, wake_irq, in_low_power}, 7'h78);
        idle_case(1, 1'h0, 1'h0, 2, 10, 1'h1);
        idle_case(0, 1'h0, 1'h0, 2, 10, 1'h1);
        idle_case(2, 1'h0, 1'h0, 2, 12, 1'h1);
        idle_case(3, 1'h0, 1'h0, 2, 12, 1'h0);
        idle_case(1, 1'h1, 1'h0, 11, 19, 1'h1);
        idle_case(1, 1'h0, 1'h1, 2, 1052, 1'h1);
        idle_refuse();
        periph_int_en = 1'h0;
        deep_case(MODE_STANDBY, 0, 1'h0, 1'h0, 26, 48, 1'h0);
        deep_case(MODE_STANDBY, 1, 1'h1, 1'h1, 16, 1139, 1'h1);
        run_from_ram = 1'h1;
        deep_case(MODE_HALT, 2, 1'h0, 1'h1, 10, 77, 1'h1);
        run_from_ram = 1'h0;
        deep_case(MODE_HALT, 3, 1'h0, 1'h1, 20, 1177, 1'h0);
        summarize();
    end
endmodule // tb
